// ===== logic/spz_serial_port.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// (RULE_01) mode bits 00: synchronous shift, 8 bits, 4 or 12 clocks per bit
// (RULE_02) mode bits 01: async 10-bit frame at external variable rate
// (RULE_03) mode bits 10: 11-bit frame at 64/32 clocks; 11: same, variable
// (RULE_04) with fe select, top bit is framing error, set on bad stop
// (RULE_05) modes 2/3 with multiproc: ninth bit 0 does not raise rx full
// (RULE_06) mode 1 with multiproc: missing stop bit does not raise rx full
// (RULE_07) mode 0: multiproc bit picks divide by 12 or by 4
// (RULE_08) reception only while rx enable is 1
// (RULE_09) modes 2/3 send the software ninth bit
// (RULE_10) rx ninth bit: ninth data bit, or stop bit in mode 1 without multiproc
// (RULE_11) tx done set after bit 8 in mode 0, at stop start otherwise
// (RULE_12) rx full set after bit 8 in mode 0, mid stop otherwise, filtered
// (RULE_13) buffer address: reads rx register, writes load and start tx
// (RULE_14) software loads the slave match value with node or broadcast address
// (RULE_15) serial irq is tx done or rx full, gated by serial enable
// (RULE_16) global enable gates all interrupts but not power fail
// (RULE_17) serial out on port 3 bit 1, serial in on port 3 bit 0
// (RULE_18) address compare only where match mask bit is 1
// (RULE_19) all-zero mask accepts any address
// (RULE_20) modes 1 and 3 use external 16x baud tick
// (RULE_21) mode 0 data lsb first on serial in pin, clock on serial out pin
module spz_serial_port
	import spz_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            rstn,
	input  wire spz_pkg::spz_bus_t bus,
	output logic [7:0]           rdata,
	input  wire logic            baud_tick,
	input  wire logic            pfi_req,
	input  wire logic            rxd_i,
	output logic                 rxd_o,
	output logic                 rxd_oe,
	output logic                 txd_o,
	output logic                 irq
);
	import spz_pkg::*;

	logic       mode_hi_reg, mode_lo_reg, mpe_reg, ren_reg, tb8_reg, rb8_reg;
	logic       ti_reg, ri_reg, fe_reg;
	logic [7:0] ie_reg, match_val_reg, match_mask_reg, pctl_reg, rx_buf_reg;
	logic [7:0] rdata_reg;
	logic       rxd_s1_reg, rxd_s2_reg;
	logic       txd_reg, rxd_o_reg, rxd_oe_reg, irq_reg;
	logic [1:0] pre_reg;
	spz_rx_state_t rx_state_reg;
	spz_tx_state_t tx_state_reg;
	logic [3:0] rx_ovs_reg, rx_bit_reg, tx_ovs_reg, tx_bit_reg;
	logic [8:0] rx_sh_reg;
	logic [10:0] tx_sh_reg;
	logic       m0_busy_reg, m0_rx_reg;
	logic [3:0] m0_cnt_reg;
	logic [2:0] m0_bit_reg;
	logic [7:0] m0_sh_reg;

	logic mode0, mode1, mode2, mode23, fe_sel;
	logic wr_ctl, wr_buf, tx_start, tick16, pre_tick;
	logic [3:0] m0_period;
	logic [1:0] pre_limit;
	logic rx_finish, rx_accept, addr_match, ninth_in, ti_set, ri_set, m0_end;
	logic [7:0] rx_data;

	// mode decode, shared by every engine
	assign mode0  = !mode_hi_reg && !mode_lo_reg; // RULE_01
	assign mode1  = !mode_hi_reg && mode_lo_reg;  // RULE_02
	assign mode2  = mode_hi_reg && !mode_lo_reg;  // RULE_03
	assign mode23 = mode_hi_reg;                  // RULE_03
	assign fe_sel = pctl_reg[PC_FE_SEL];
	assign wr_ctl = bus.wr && bus.addr == SERIAL_CONTROL_ADDR;
	assign wr_buf = bus.wr && bus.addr == SERIAL_BUFFER_ADDR;
	assign tx_start = wr_buf; // RULE_13

	// rate selection: mode 2 divides core_clk, modes 1/3 use the timer tick
	assign m0_period = mpe_reg ? M0_FAST_CYC : M0_SLOW_CYC; // RULE_07
	assign pre_limit = pctl_reg[PC_DOUBLE] ? M2_TICK_FAST : M2_TICK_SLOW;
	assign pre_tick  = pre_reg == pre_limit;
	assign tick16    = mode2 ? pre_tick : baud_tick; // RULE_20

	// receive decisions at mid stop bit
	assign rx_finish  = rx_state_reg == RX_DATA && tick16 && rx_ovs_reg == OVS_LAST
		&& rx_bit_reg == (mode1 ? DATA_M1 : DATA_M23);
	assign rx_data    = mode1 ? rx_sh_reg[8:1] : rx_sh_reg[7:0];
	assign ninth_in   = rx_sh_reg[8];
	// a cleared mask bit drops out of the compare, so an all-zero mask matches
	assign addr_match = ((rx_data ^ match_val_reg) & match_mask_reg) == 8'h00; // RULE_18 RULE_19
	always_comb
	begin
		rx_accept = 1'b1;
		if (mpe_reg && mode1 && !rxd_s2_reg)
			rx_accept = 1'b0; // RULE_06
		if (mpe_reg && mode23 && (!ninth_in || !addr_match))
			rx_accept = 1'b0; // RULE_05
	end
	assign m0_end = m0_busy_reg && m0_cnt_reg == m0_period - 4'd1
		&& m0_bit_reg == M0_LAST_BIT;
	assign ti_set = (m0_end && !m0_rx_reg)
		|| (tx_state_reg == TX_SEND && tick16 && tx_ovs_reg == OVS_LAST
		&& tx_bit_reg == (mode1 ? BITS_M1 : BITS_M23) - 4'd2); // RULE_11
	assign ri_set = (m0_end && m0_rx_reg) || (rx_finish && rx_accept); // RULE_12

	// pin synchroniser, first stage read only by the second
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rxd_s1_reg <= 1'b1;
			rxd_s2_reg <= 1'b1;
		end
		else
		begin
			rxd_s1_reg <= rxd_i; // RULE_17
			rxd_s2_reg <= rxd_s1_reg;
		end
	end

	// serial control: hardware sets win over a software clear in the same cycle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			{mode_hi_reg, mode_lo_reg, mpe_reg, ren_reg} <= CTL_RESET[7:4];
			{tb8_reg, rb8_reg, ti_reg, ri_reg} <= CTL_RESET[3:0];
			fe_reg <= 1'b0;
		end
		else
		begin
			if (wr_ctl)
			begin
				if (!fe_sel)
					mode_hi_reg <= bus.wdata[CTL_MODE_HI];
				mode_lo_reg <= bus.wdata[CTL_MODE_LO];
				mpe_reg     <= bus.wdata[CTL_MPE];
				ren_reg     <= bus.wdata[CTL_REN];
				tb8_reg     <= bus.wdata[CTL_TB8];
			end
			if (rx_finish && rx_accept && (mode23 || !mpe_reg))
				rb8_reg <= mode23 ? ninth_in : rxd_s2_reg; // RULE_10
			else if (wr_ctl)
				rb8_reg <= bus.wdata[CTL_RB8];
			if (ti_set)
				ti_reg <= 1'b1; // RULE_11
			else if (wr_ctl)
				ti_reg <= bus.wdata[CTL_TI];
			if (ri_set)
				ri_reg <= 1'b1; // RULE_12
			else if (wr_ctl)
				ri_reg <= bus.wdata[CTL_RI];
			if (rx_finish && !rxd_s2_reg)
				fe_reg <= 1'b1; // RULE_04
			else if (wr_ctl && fe_sel)
				fe_reg <= bus.wdata[CTL_MODE_HI];
		end
	end

	// plain software registers
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ie_reg         <= REG_RESET;
			match_val_reg  <= REG_RESET;
			match_mask_reg <= REG_RESET;
			pctl_reg       <= REG_RESET;
		end
		else if (bus.wr)
		begin
			case (bus.addr)
				IRQ_ENABLE_ADDR:       ie_reg <= bus.wdata;
				SLAVE_MATCH_VAL_ADDR:  match_val_reg <= bus.wdata; // RULE_14
				SLAVE_MATCH_MASK_ADDR: match_mask_reg <= bus.wdata;
				POWER_CONTROL_ADDR:    pctl_reg <= bus.wdata;
				default:               ie_reg <= ie_reg;
			endcase
		end
	end

	// read port, data one cycle after the strobe
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			rdata_reg <= RD_UNMAPPED;
		else if (bus.rd)
		begin
			case (bus.addr)
				SERIAL_CONTROL_ADDR: rdata_reg <= {fe_sel ? fe_reg : mode_hi_reg,
					mode_lo_reg, mpe_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg}; // RULE_04
				SERIAL_BUFFER_ADDR:    rdata_reg <= rx_buf_reg; // RULE_13
				IRQ_ENABLE_ADDR:       rdata_reg <= ie_reg;
				SLAVE_MATCH_VAL_ADDR:  rdata_reg <= match_val_reg;
				SLAVE_MATCH_MASK_ADDR: rdata_reg <= match_mask_reg;
				POWER_CONTROL_ADDR:    rdata_reg <= pctl_reg;
				default:               rdata_reg <= RD_UNMAPPED;
			endcase
		end
		else
			rdata_reg <= RD_UNMAPPED;
	end

	// mode 2 prescaler, free running
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			pre_reg <= 2'd0;
		else
			pre_reg <= pre_tick ? 2'd0 : pre_reg + 2'd1;
	end

	// async transmitter: start, 8 data, ninth or stop, stop; lsb first
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_state_reg <= TX_IDLE;
			tx_sh_reg    <= '1;
			tx_ovs_reg   <= 4'd0;
			tx_bit_reg   <= 4'd0;
		end
		else
		begin
			case (tx_state_reg)
				TX_IDLE:
					if (tx_start && !mode0)
					begin
						tx_sh_reg  <= {1'b1, mode23 ? tb8_reg : 1'b1,
							bus.wdata, 1'b0}; // RULE_09
						tx_ovs_reg <= 4'd0;
						tx_bit_reg <= 4'd0;
						tx_state_reg <= TX_SEND;
					end
				TX_SEND:
					if (tick16)
					begin
						tx_ovs_reg <= tx_ovs_reg + 4'd1;
						if (tx_ovs_reg == OVS_LAST)
						begin
							tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
							tx_bit_reg <= tx_bit_reg + 4'd1;
							if (tx_bit_reg == (mode1 ? BITS_M1 : BITS_M23) - 4'd1)
								tx_state_reg <= TX_IDLE; // RULE_02 RULE_03
						end
					end
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// async receiver, 16x oversampled, sampling at mid bit
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_state_reg <= RX_IDLE;
			rx_ovs_reg   <= 4'd0;
			rx_bit_reg   <= 4'd0;
			rx_sh_reg    <= 9'h000;
		end
		else if (!ren_reg || mode0)
			rx_state_reg <= RX_IDLE; // RULE_08
		else if (tick16)
		begin
			rx_ovs_reg <= rx_ovs_reg + 4'd1;
			case (rx_state_reg)
				RX_IDLE:
					if (!rxd_s2_reg)
					begin
						rx_ovs_reg   <= 4'd0;
						rx_state_reg <= RX_START;
					end
				RX_START:
					if (rx_ovs_reg == OVS_MID)
					begin
						// a start bit gone high by mid bit is noise
						rx_state_reg <= rxd_s2_reg ? RX_IDLE : RX_DATA;
						rx_ovs_reg   <= 4'd0;
						rx_bit_reg   <= 4'd0;
					end
				RX_DATA:
					if (rx_ovs_reg == OVS_LAST)
					begin
						rx_bit_reg <= rx_bit_reg + 4'd1;
						if (rx_finish)
							rx_state_reg <= RX_IDLE;
						else
							rx_sh_reg <= {rxd_s2_reg, rx_sh_reg[8:1]};
					end
				default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// mode 0 shift engine: a buffer write sends, else rx enable with rx full clear receives
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			m0_busy_reg <= 1'b0;
			m0_rx_reg   <= 1'b0;
			m0_cnt_reg  <= 4'd0;
			m0_bit_reg  <= 3'd0;
			m0_sh_reg   <= 8'h00;
		end
		else if (!mode0)
			m0_busy_reg <= 1'b0;
		else if (!m0_busy_reg)
		begin
			m0_cnt_reg <= 4'd0;
			m0_bit_reg <= 3'd0;
			if (tx_start || (ren_reg && !ri_reg))
			begin
				m0_busy_reg <= 1'b1;
				m0_rx_reg   <= !tx_start;
				m0_sh_reg   <= bus.wdata;
			end
		end
		else if (m0_cnt_reg == m0_period - 4'd1)
		begin
			// clock ends its high half here and falls next; capture or move to the next bit, lsb first
			m0_cnt_reg <= 4'd0;
			m0_bit_reg <= m0_bit_reg + 3'd1;
			m0_sh_reg  <= {m0_rx_reg ? rxd_s2_reg : 1'b1, m0_sh_reg[7:1]}; // RULE_21
			if (m0_bit_reg == M0_LAST_BIT)
				m0_busy_reg <= 1'b0; // RULE_01
		end
		else
			m0_cnt_reg <= m0_cnt_reg + 4'd1;
	end

	// receive buffer loads only on an accepted frame
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			rx_buf_reg <= 8'h00;
		else if (m0_end && m0_rx_reg)
			rx_buf_reg <= {rxd_s2_reg, m0_sh_reg[7:1]};
		else if (rx_finish && rx_accept)
			rx_buf_reg <= rx_data; // RULE_12
	end

	// pins and interrupt, all registered
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			txd_reg    <= 1'b1;
			rxd_o_reg  <= 1'b1;
			rxd_oe_reg <= 1'b0;
			irq_reg    <= 1'b0;
		end
		else
		begin
			// shift clock is low for the first half of each bit
			txd_reg    <= mode0 ? !(m0_busy_reg && m0_cnt_reg < (m0_period >> 1))
				: tx_sh_reg[0]; // RULE_17 RULE_21
			rxd_o_reg  <= m0_sh_reg[0];
			rxd_oe_reg <= mode0 && m0_busy_reg && !m0_rx_reg; // RULE_21
			irq_reg    <= pfi_req || (ie_reg[IE_GLOBAL] && ie_reg[IE_SERIAL]
				&& (ti_reg || ri_reg)); // RULE_15 RULE_16
		end
	end

	assign rdata  = rdata_reg;
	assign txd_o  = txd_reg;
	assign rxd_o  = rxd_o_reg;
	assign rxd_oe = rxd_oe_reg;
	assign irq    = irq_reg;

	// checks
	a_ti_sticky: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_11
		ti_reg && !wr_ctl |=> ti_reg) else $error("tx done dropped");
	a_ri_sticky: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_12
		ri_reg && !wr_ctl |=> ri_reg) else $error("rx full dropped");
	a_fe_bad_stop: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_04
		rx_finish && !rxd_s2_reg |=> fe_reg) else $error("framing error missed");
	a_mpe_ninth: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_05
		rx_finish && mode23 && mpe_reg && !ninth_in && !ri_reg && !wr_ctl && !m0_end
		|=> !ri_reg) else $error("rx full on ninth bit 0");
	a_mpe_stop: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_06
		rx_finish && mode1 && mpe_reg && !rxd_s2_reg && !ri_reg && !wr_ctl
		|=> !ri_reg) else $error("rx full on bad stop");
	a_rx_disabled: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_08
		!ren_reg |=> rx_state_reg == RX_IDLE) else $error("rx runs while disabled");
	a_m0_fast_clk: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_07
		m0_busy_reg && mpe_reg && $stable(mpe_reg) |-> m0_cnt_reg <= 4'd3)
		else $error("mode 0 fast period wrong");
	a_tx_ninth: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_09
		tx_start && mode23 && tx_state_reg == TX_IDLE |=> tx_sh_reg[9] == $past(tb8_reg))
		else $error("ninth bit not loaded");
	a_buf_read: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_13
		bus.rd && bus.addr == SERIAL_BUFFER_ADDR |=> rdata == $past(rx_buf_reg))
		else $error("buffer read wrong");
	a_irq_gate: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_16
		!pfi_req && !(ie_reg[IE_GLOBAL] && ie_reg[IE_SERIAL]) |=> !irq)
		else $error("irq without enable");
endmodule : spz_serial_port

// ===== logic/spz_pkg.sv
package spz_pkg;
	// register addresses
	localparam logic [7:0] SERIAL_CONTROL_ADDR   = 8'h98;
	localparam logic [7:0] SERIAL_BUFFER_ADDR    = 8'h99;
	localparam logic [7:0] IRQ_ENABLE_ADDR       = 8'ha8;
	localparam logic [7:0] SLAVE_MATCH_VAL_ADDR  = 8'ha9;
	localparam logic [7:0] SLAVE_MATCH_MASK_ADDR = 8'hb9;
	localparam logic [7:0] POWER_CONTROL_ADDR    = 8'hc8;
	// serial control field positions
	localparam int CTL_MODE_HI = 7;
	localparam int CTL_MODE_LO = 6;
	localparam int CTL_MPE     = 5;
	localparam int CTL_REN     = 4;
	localparam int CTL_TB8     = 3;
	localparam int CTL_RB8     = 2;
	localparam int CTL_TI      = 1;
	localparam int CTL_RI      = 0;
	// interrupt enable and power control fields
	localparam int IE_GLOBAL   = 7;
	localparam int IE_SERIAL   = 4;
	localparam int PC_DOUBLE   = 7;
	localparam int PC_FE_SEL   = 6;
	// reset values
	localparam logic [7:0] CTL_RESET  = 8'h00;
	localparam logic [7:0] REG_RESET  = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// timing counts: core_clk cycles for mode 0 and the prescaler, 16x ticks and bit counts for the rest
	localparam logic [3:0] M0_SLOW_CYC = 4'd12;
	localparam logic [3:0] M0_FAST_CYC = 4'd4;
	localparam logic [1:0] M2_TICK_SLOW = 2'd3;  // 64 clocks per bit / 16
	localparam logic [1:0] M2_TICK_FAST = 2'd1;  // 32 clocks per bit / 16
	localparam logic [3:0] OVS_LAST  = 4'd15;
	localparam logic [3:0] OVS_MID   = 4'd7;
	localparam logic [3:0] BITS_M1   = 4'd10;
	localparam logic [3:0] BITS_M23  = 4'd11;
	localparam logic [3:0] DATA_M1   = 4'd8;
	localparam logic [3:0] DATA_M23  = 4'd9;
	localparam logic [2:0] M0_LAST_BIT = 3'd7;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} spz_bus_t;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} spz_rx_state_t;
	typedef enum logic {TX_IDLE, TX_SEND} spz_tx_state_t;
endpackage : spz_pkg

// ===== tb/spz_remote_station.sv
`timescale 1ns/1ps
// far station on the serial pins: frames go lsb first, start bit first
module spz_remote_station
(
	input  wire logic core_clk,
	input  wire logic txd,
	output logic      rxd
);
	// idle level is high, as on a pulled-up port pin
	initial rxd = 1'b1;

	// drive n bits of f, each held per clocks, then release to idle
	task automatic send(input logic [10:0] f, input int n, input int per);
		for (int i = 0; i < n; i++)
		begin
			rxd <= f[i];
			repeat (per) @(posedge core_clk);
		end
		rxd <= 1'b1;
	endtask : send

	// hunt for a start bit under a bound, then sample each bit mid-cell
	task automatic get(input int n, input int per, output logic [10:0] f);
		int t;
		f = '0;
		t = 0;
		while (txd !== 1'b0 && t < 200)
		begin
			@(posedge core_clk);
			t++;
		end
		repeat (per / 2) @(posedge core_clk);
		for (int i = 0; i < n; i++)
		begin
			f[i] = txd;
			repeat (per) @(posedge core_clk);
		end
	endtask : get

	// shift mode slave: put the next bit out after each falling shift clock, lsb first;
	// hold the last bit well past its capture edge before releasing the line
	task automatic shift_out(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			@(negedge txd);
			rxd <= b[i];
		end
		repeat (16) @(posedge core_clk);
		rxd <= 1'b1;
	endtask : shift_out
endmodule : spz_remote_station

// ===== tb/test_serial_port_zero_uart.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_serial_port_zero_uart;
	import spz_pkg::*;
	logic        core_clk = 0;
	logic        rstn = 0;
	logic        baud_tick = 0;
	logic        pfi_req = 0;
	spz_bus_t    bus = '0;
	logic [7:0]  rdata;
	logic        rxd_o, rxd_oe, txd_o, irq, st_rxd, m0_on = 0, prev = 1;
	int          mismatches = 0, check_count = 0, cycles = 0, seed = 32'h1a58;
	logic [7:0]  d, v;
	logic [10:0] f;
	logic        rq[$];
	int          cq[$];
	logic [7:0]  ra[6] = '{8'h98, 8'ha8, 8'ha9, 8'hb9, 8'hc8, 8'h9a};
	logic [7:0]  ie_v[3] = '{8'h10, 8'h90, 8'h80};
	logic        ie_q[3] = '{1'b0, 1'b1, 1'b0};
	// the shared pin: the port drives it only in shift mode
	wire         rxd_line = rxd_oe ? rxd_o : st_rxd;

	always #20 core_clk = ~core_clk;

	// tick every 4 clocks so modes 1 and 3 run 64 clocks per bit; hang guard
	always @(posedge core_clk)
	begin
		baud_tick <= (cycles % 4 == 3);
		cycles++;
		if (cycles == 40000)
		begin
			mismatches++;
			print_verdict();
		end
	end

	// shift mode monitor: data pin value at each rising shift clock
	always @(posedge core_clk)
	begin
		prev <= txd_o;
		if (m0_on && txd_o && !prev)
		begin
			rq.push_back(rxd_o);
			cq.push_back(cycles);
		end
	end

	spz_serial_port dut_u (.core_clk(core_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
		.baud_tick(baud_tick), .pfi_req(pfi_req), .rxd_i(rxd_line), .rxd_o(rxd_o),
		.rxd_oe(rxd_oe), .txd_o(txd_o), .irq(irq));
	spz_remote_station st_u (.core_clk(core_clk), .txd(txd_o), .rxd(st_rxd));

	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus <= '0;
		@(posedge core_clk);
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus <= '0;
		#1 r = rdata;
		@(posedge core_clk);
	endtask : rd

	// reference: does a received frame raise rx full (b9 is stop bit in mode 1)
	function automatic logic exp_ri(int mode, logic mpe, logic [7:0] dt, logic b9,
		logic [7:0] va, logic [7:0] mk);
		if (mode == 1)
			return !mpe || b9;
		return !mpe || (b9 && ((dt ^ va) & mk) == 8'h00);
	endfunction : exp_ri

	task automatic tx_case(input int mode, input logic t8, input int per);
		d = 8'($random(seed));
		wr(SERIAL_CONTROL_ADDR, {mode[1:0], 2'b00, t8, 3'h0});
		wr(SERIAL_BUFFER_ADDR, d);
		st_u.get((mode == 1) ? 10 : 11, per, f);
		`CHK(f, (mode == 1) ? {2'b01, d, 1'b0} : {1'b1, t8, d, 1'b0})
		rd(SERIAL_CONTROL_ADDR, v);
		`CHK(v[CTL_TI], 1'b1)
	endtask : tx_case

	task automatic rx_case(input int mode, input logic mpe, input logic ren, input logic b9,
		input logic [7:0] va, input logic [7:0] mk);
		logic e;
		d = 8'($random(seed));
		e = ren && exp_ri(mode, mpe, d, b9, va, mk);
		wr(SLAVE_MATCH_VAL_ADDR, va);
		wr(SLAVE_MATCH_MASK_ADDR, mk);
		wr(SERIAL_CONTROL_ADDR, {mode[1:0], mpe, ren, 4'h0});
		st_u.send({1'b1, b9, d, 1'b0}, (mode == 1) ? 10 : 11, 64);
		repeat (4) @(posedge core_clk);
		rd(SERIAL_CONTROL_ADDR, v);
		`CHK(v[CTL_RI], e)
		if (mode == 1)
			`CHK(v[CTL_MODE_HI], ren & !b9)
		if (e && !(mode == 1 && mpe))
			`CHK(v[CTL_RB8], b9)
		if (e)
		begin
			rd(SERIAL_BUFFER_ADDR, v);
			`CHK(v, d)
		end
	endtask : rx_case

	// shift mode transmit: eight rising clocks, lsb first, period 12 or 4
	task automatic m0_case(input logic mpe);
		d = 8'($random(seed));
		wr(SERIAL_CONTROL_ADDR, {2'b00, mpe, 5'h00});
		rq.delete();
		cq.delete();
		m0_on = 1;
		wr(SERIAL_BUFFER_ADDR, d);
		repeat (110) @(posedge core_clk);
		m0_on = 0;
		`CHK(rq.size(), 8)
		for (int i = 0; i < rq.size(); i++)
		begin
			`CHK(rq[i], d[i])
			if (i > 0)
				`CHK(cq[i] - cq[i - 1], mpe ? 4 : 12)
		end
		rd(SERIAL_CONTROL_ADDR, v);
		`CHK(v[CTL_TI], 1'b1)
	endtask : m0_case

	task automatic print_verdict();
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	// main sequence: registers, transmit, receive with filters, interrupts, shift mode
	initial
	begin
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		foreach (ra[i])
		begin
			rd(ra[i], v);
			`CHK(v, 8'h00)
		end
		for (int i = 2; i < 4; i++)
		begin
			d = 8'($random(seed));
			wr(ra[i], d);
			rd(ra[i], v);
			`CHK(v, d)
		end
		tx_case(1, 1'b0, 64);
		tx_case(3, 1'b1, 64);
		tx_case(3, 1'b0, 64);
		tx_case(2, 1'b1, 64);
		wr(POWER_CONTROL_ADDR, 8'h80);
		tx_case(2, 1'b0, 32);
		// framing error view on for the mode 1 receive cases; the mode bits are set
		// first, since the top bit stops being writable as a mode bit once the view is on
		wr(SERIAL_CONTROL_ADDR, 8'h40);
		wr(POWER_CONTROL_ADDR, 8'h40);
		rx_case(1, 1'b0, 1'b1, 1'b1, 8'h00, 8'h00);
		rx_case(1, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
		rx_case(1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
		rx_case(1, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		wr(POWER_CONTROL_ADDR, 8'h00);
		rx_case(3, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
		rx_case(3, 1'b1, 1'b1, 1'b1, 8'h5a, 8'h00);
		rx_case(3, 1'b1, 1'b1, 1'b1, 8'($random(seed)), 8'hff);
		rx_case(2, 1'b0, 1'b1, 1'b1, 8'h00, 8'h00);
		// rx full is now pending: walk the enable combinations
		for (int i = 0; i < 3; i++)
		begin
			wr(IRQ_ENABLE_ADDR, ie_v[i]);
			repeat (2) @(posedge core_clk);
			`CHK(irq, ie_q[i])
		end
		pfi_req <= 1'b1;
		wr(IRQ_ENABLE_ADDR, 8'h00);
		repeat (2) @(posedge core_clk);
		`CHK(irq, 1'b1)
		pfi_req <= 1'b0;
		m0_case(1'b0);
		m0_case(1'b1);
		// shift mode receive: fast clock, rx enable with rx full clear starts it
		d = 8'($random(seed));
		wr(SERIAL_CONTROL_ADDR, 8'h30);
		st_u.shift_out(d);
		rd(SERIAL_CONTROL_ADDR, v);
		`CHK(v[CTL_RI], 1'b1)
		rd(SERIAL_BUFFER_ADDR, v);
		`CHK(v, d)
		print_verdict();
	end
endmodule : test_serial_port_zero_uart
